// file: core/clcr_pkg.sv
package clcr_pkg;
   // Register locations
   localparam logic [7:0] TERM_ADDR = 8'h04;
   localparam logic [7:0] VBAT_ADDR = 8'h05;
   localparam logic [7:0] SYS_ADDR = 8'h06;
   // Reset values
   localparam logic [7:0] TERM_RESET = 8'h0e;
   localparam logic [7:0] VBAT_RESET = 8'h78;
   localparam logic [7:0] SYS_RESET = 8'haa;
   // Termination register fields
   localparam int TERM_RANGE_BIT = 7;
   localparam int TERM_CODE_MSB = 6;
   localparam int TERM_CODE_LSB = 2;
   localparam int TERM_EN_BIT = 1;
   // Low range current: 500 uA * (code + 1), at most 5 mA
   localparam logic [4:0] TERM_LOW_MAX_CODE = 5'h09;
   localparam int TERM_LOW_STEP_UA = 500;
   localparam int TERM_LOW_BASE_UA = 500;
   localparam int TERM_HIGH_STEP_UA = 1000;
   localparam int TERM_HIGH_BASE_UA = 6000;
   // Battery voltage fields: 3.6 V + code * 10 mV, at most 4.65 V
   localparam int VBAT_CODE_MSB = 7;
   localparam int VBAT_CODE_LSB = 1;
   localparam logic [6:0] VBAT_MAX_CODE = 7'h69;
   localparam int VBAT_BASE_MV = 3600;
   localparam int VBAT_STEP_MV = 10;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
endpackage : clcr_pkg

// file: core/clcr_clamp.sv
`timescale 1ns/1ps
`default_nettype none
module clcr_clamp #(
   parameter int WIDTH = 5
) (
   // Raw code and limit
   input wire logic [WIDTH-1:0] code_in,
   input wire logic [WIDTH-1:0] max_code,
   input wire logic limit_on,
   // Clamped code
   output logic [WIDTH-1:0] code_out
);
   if (WIDTH < 1) begin : g_width
      $error("Clamp width must be at least one bit");
   end
   wire over = limit_on && (code_in > max_code);
   assign code_out = over ? max_code : code_in;
endmodule : clcr_clamp
`default_nettype wire

// file: core/clcr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module clcr_regs (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // Register port from the serial interface
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Power-up defaults
   input wire logic default_load,
   input wire logic term_pin_grounded,
   input wire logic [7:0] term_pin_default,
   input wire logic [7:0] term_otp_default,
   input wire logic [7:0] vbat_otp_default,
   // Regulation loop status
   input wire logic cc_loop_active,
   input wire logic voltage_regulation_loop,
   // Charger settings
   output logic term_range_select,
   output logic [4:0] term_current_code,
   output logic term_active,
   output logic [15:0] term_current_ua,
   output logic [6:0] batt_reg_voltage_code,
   output logic [12:0] batt_reg_target_mv,
   output logic [7:0] system_output_voltage
);
   logic [7:0] termination_precharge_current;
   logic [7:0] battery_regulation_voltage;
   logic [7:0] system_output_voltage_q;

   // Shared by the write strobes and the read mux
   function automatic logic addr_hit(input logic [7:0] addr,
                                     input logic [7:0] loc);
      return addr == loc;
   endfunction : addr_hit

   wire term_sel = addr_hit(reg_addr, clcr_pkg::TERM_ADDR);
   wire vbat_sel = addr_hit(reg_addr, clcr_pkg::VBAT_ADDR);
   wire sys_sel = addr_hit(reg_addr, clcr_pkg::SYS_ADDR);

   wire [7:0] term_default = term_pin_grounded ? term_otp_default
                                               : term_pin_default;
   wire [7:0] term_src = default_load ? term_default : reg_wdata;
   wire [7:0] vbat_src = default_load ? vbat_otp_default : reg_wdata;
   wire term_load = default_load || (reg_wr && term_sel);
   wire vbat_load = default_load || (reg_wr && vbat_sel);
   wire sys_load = reg_wr && sys_sel;

   logic [4:0] term_code_clamped;
   logic [6:0] vbat_code_clamped;

   clcr_clamp #(.WIDTH(5)) u_term_clamp (
      .code_in(term_src[clcr_pkg::TERM_CODE_MSB:clcr_pkg::TERM_CODE_LSB]),
      .max_code(clcr_pkg::TERM_LOW_MAX_CODE),
      .limit_on(!term_src[clcr_pkg::TERM_RANGE_BIT]),
      .code_out(term_code_clamped)
   );

   clcr_clamp #(.WIDTH(7)) u_vbat_clamp (
      .code_in(vbat_src[clcr_pkg::VBAT_CODE_MSB:clcr_pkg::VBAT_CODE_LSB]),
      .max_code(clcr_pkg::VBAT_MAX_CODE),
      .limit_on(1'b1),
      .code_out(vbat_code_clamped)
   );

   // stored value is the saturated one
   wire [7:0] next_term = {term_src[7], term_code_clamped, term_src[1:0]};
   wire [7:0] next_vbat = {vbat_code_clamped, vbat_src[0]};

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         termination_precharge_current <= clcr_pkg::TERM_RESET;
      end else if (term_load) begin
         termination_precharge_current <= next_term;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         battery_regulation_voltage <= clcr_pkg::VBAT_RESET;
      end else if (vbat_load) begin
         battery_regulation_voltage <= next_vbat;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         system_output_voltage_q <= clcr_pkg::SYS_RESET;
      end else if (sys_load) begin
         system_output_voltage_q <= reg_wdata;
      end
   end

   // Decoded settings
   wire [7:0] term_q = termination_precharge_current;
   wire [4:0] tcode = term_q[clcr_pkg::TERM_CODE_MSB:clcr_pkg::TERM_CODE_LSB];
   wire [7:0] vbat_q = battery_regulation_voltage;
   wire [6:0] vcode = vbat_q[clcr_pkg::VBAT_CODE_MSB:clcr_pkg::VBAT_CODE_LSB];
   wire [15:0] low_ua = 16'(clcr_pkg::TERM_LOW_BASE_UA +
                            int'(tcode) * clcr_pkg::TERM_LOW_STEP_UA);
   wire [15:0] high_ua = 16'(clcr_pkg::TERM_HIGH_BASE_UA +
                             int'(tcode) * clcr_pkg::TERM_HIGH_STEP_UA);
   wire [15:0] next_term_ua = term_q[clcr_pkg::TERM_RANGE_BIT] ? high_ua
                                                              : low_ua;
   wire [12:0] next_vbat_mv = 13'(clcr_pkg::VBAT_BASE_MV +
                                  int'(vcode) * clcr_pkg::VBAT_STEP_MV);
   // only CC or voltage loop permits termination
   wire next_term_active = term_q[clcr_pkg::TERM_EN_BIT] &&
                           (cc_loop_active || voltage_regulation_loop);

   // Decoded values must fit their ports, or the casts above would wrap
   localparam int TERM_CODE_TOP = (1 << $bits(term_current_code)) - 1;
   localparam int TERM_UA_TOP = clcr_pkg::TERM_HIGH_BASE_UA +
                                TERM_CODE_TOP * clcr_pkg::TERM_HIGH_STEP_UA;
   localparam int VBAT_MV_TOP = clcr_pkg::VBAT_BASE_MV +
      int'(clcr_pkg::VBAT_MAX_CODE) * clcr_pkg::VBAT_STEP_MV;
   if (TERM_UA_TOP >= (1 << $bits(term_current_ua))) begin : g_ua_fit
      $error("Termination current does not fit its port");
   end
   if (VBAT_MV_TOP >= (1 << $bits(batt_reg_target_mv))) begin : g_mv_fit
      $error("Battery target does not fit its port");
   end
   // Field positions must match the code widths and the byte
   if (clcr_pkg::TERM_CODE_MSB - clcr_pkg::TERM_CODE_LSB + 1 !=
       $bits(term_current_code)) begin : g_term_field
      $error("Termination code field has the wrong width");
   end
   if (clcr_pkg::VBAT_CODE_MSB - clcr_pkg::VBAT_CODE_LSB + 1 !=
       $bits(batt_reg_voltage_code)) begin : g_vbat_field
      $error("Battery code field has the wrong width");
   end
   if (clcr_pkg::TERM_RANGE_BIT > 7 ||
       clcr_pkg::VBAT_CODE_MSB > 7) begin : g_in_byte
      $error("Field lies outside the register byte");
   end

   wire [7:0] next_rdata = term_sel ? termination_precharge_current :
                           vbat_sel ? battery_regulation_voltage :
                           sys_sel ? system_output_voltage_q :
                           clcr_pkg::READ_UNMAPPED;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

   // Termination settings to the charger
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         term_range_select <= 1'b0;
         term_current_code <= 5'h00;
         term_current_ua <= 16'h0000;
      end else begin
         term_range_select <= term_q[clcr_pkg::TERM_RANGE_BIT];
         term_current_code <= tcode;
         term_current_ua <= next_term_ua;
      end
   end

   // Termination permit, follows loop status every cycle
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         term_active <= 1'b0;
      end else begin
         term_active <= next_term_active;
      end
   end

   // Battery regulation settings to the charger
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         batt_reg_voltage_code <= 7'h00;
         batt_reg_target_mv <= 13'h0000;
      end else begin
         batt_reg_voltage_code <= vcode;
         batt_reg_target_mv <= next_vbat_mv;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         system_output_voltage <= 8'h00;
      end else begin
         system_output_voltage <= system_output_voltage_q;
      end
   end
endmodule : clcr_regs
`default_nettype wire

// file: testbench/clcr_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module clcr_regs_monitor (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // Register port
   input wire logic reg_wr,
   input wire logic default_load,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // Loop status and settings
   input wire logic cc_loop_active,
   input wire logic voltage_regulation_loop,
   input wire logic term_range_select,
   input wire logic term_active,
   input wire logic [4:0] term_current_code,
   input wire logic [15:0] term_current_ua,
   input wire logic [6:0] batt_reg_voltage_code,
   input wire logic [12:0] batt_reg_target_mv
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   wire vb = reg_addr == clcr_pkg::VBAT_ADDR;
   wire vb_wr = reg_wr && !default_load && vb;
   wire big = reg_wdata[7:1] > clcr_pkg::VBAT_MAX_CODE;
   wire unmap = reg_addr < 8'h04 || reg_addr > 8'h06;
   wire no_loop = !cc_loop_active && !voltage_regulation_loop;
   AST_VBAT_MV: assert property (
      !$past(srst) |-> batt_reg_target_mv ==
      13'h0e10 + 13'h000a * batt_reg_voltage_code) else $error("mv");
   AST_TERM_UA: assert property (
      !$past(srst) |-> term_current_ua == (term_range_select ?
      16'h1770 + 16'h03e8 * term_current_code :
      16'h01f4 + 16'h01f4 * term_current_code)) else $error("ua");
   AST_TERM_CLAMP: assert property (
      !term_range_select |-> term_current_code <= 5'h09)
      else $error("term clamp");
   AST_VBAT_WR: assert property (
      vb_wr && !big |-> ##2 {batt_reg_voltage_code, 1'b0} ==
      ($past(reg_wdata, 2) & 8'hfe)) else $error("vbat write");
   AST_VBAT_SAT: assert property (
      vb_wr && big |-> ##2 batt_reg_voltage_code == 7'h69)
      else $error("vbat sat");
   AST_UNMAPPED: assert property (
      unmap |=> reg_rdata == 8'h00) else $error("unmapped");
   AST_READBACK: assert property (
      vb && !$past(srst) |=> reg_rdata[7:1] == batt_reg_voltage_code)
      else $error("readback");
   AST_TERM_OFF: assert property (
      no_loop [*2] |-> !term_active) else $error("term active");
   cover property (vb_wr && big);
   cover property (term_range_select);
   cover property (no_loop);
endmodule : clcr_regs_monitor
bind clcr_regs clcr_regs_monitor MON (.sys_clk, .srst, .reg_wr,
   .default_load, .reg_addr, .reg_wdata, .reg_rdata, .cc_loop_active,
   .voltage_regulation_loop, .term_range_select, .term_active,
   .term_current_code, .term_current_ua, .batt_reg_voltage_code,
   .batt_reg_target_mv);
`default_nettype wire

// file: testbench/clcr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module clcr_host_model (
   // Clock and answer
   input wire logic sys_clk,
   input wire logic [7:0] reg_rdata,
   // Requests
   output logic reg_wr = 1'b0,
   output logic [7:0] reg_addr = 8'h00,
   output logic [7:0] reg_wdata = 8'h00
);
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      // Released data lines carry junk
      reg_wdata <= ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      repeat (2) @(posedge sys_clk);
      #1 d = reg_rdata;
   endtask : rd
endmodule : clcr_host_model
`default_nettype wire

// file: testbench/charge_limit_config_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module charge_limit_config_regs_tb;
   logic sys_clk = 1'b0, srst = 1'b1, default_load = 1'b0, reg_wr;
   logic term_pin_grounded = 1'b0, cc_loop_active = 1'b1;
   logic voltage_regulation_loop = 1'b0, term_range_select, term_active;
   logic [7:0] term_pin_default = 8'h0a, term_otp_default = 8'h86;
   logic [7:0] vbat_otp_default = 8'hff, reg_rdata, reg_addr, reg_wdata;
   logic [7:0] system_output_voltage;
   logic [4:0] term_current_code;
   logic [15:0] term_current_ua;
   logic [6:0] batt_reg_voltage_code;
   logic [12:0] batt_reg_target_mv;
   int fails = 0, compares = 0;
   clcr_host_model HOST (.sys_clk, .reg_rdata, .reg_wr, .reg_addr,
      .reg_wdata);
   clcr_regs DUT (.sys_clk, .srst, .reg_wr, .reg_addr, .reg_wdata,
      .reg_rdata, .default_load, .term_pin_grounded, .term_pin_default,
      .term_otp_default, .vbat_otp_default, .cc_loop_active,
      .voltage_regulation_loop, .term_range_select, .term_current_code,
      .term_active, .term_current_ua, .batt_reg_voltage_code,
      .batt_reg_target_mv, .system_output_voltage);
   initial forever #12.5 sys_clk = ~sys_clk;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("Error %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      HOST.rd(a, d);
      chk(d, exp);
   endtask : rdchk
   task automatic tally_and_finish;
      if (fails == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish
   task automatic t_vbat;
      HOST.wr(8'h05, 8'hff);
      rdchk(8'h05, 8'hd3);
      chk(batt_reg_target_mv, 13'h122a);
      chk(batt_reg_voltage_code, 7'h69);
      HOST.wr(8'h05, 8'hd1);
      rdchk(8'h05, 8'hd1);
      chk(batt_reg_target_mv, 13'h1220);
   endtask : t_vbat
   task automatic t_term;
      HOST.wr(clcr_pkg::TERM_ADDR, 8'hfe);
      repeat (2) @(posedge sys_clk);
      #1 chk(term_current_ua, 16'h9088);
      chk({term_range_select, term_current_code}, 6'h3f);
      HOST.wr(clcr_pkg::TERM_ADDR, 8'h7c);
      rdchk(clcr_pkg::TERM_ADDR, 8'h24);
      chk({term_range_select, term_current_code}, 6'h09);
      chk({term_active, term_current_ua}, 17'h0_1388);
      HOST.wr(clcr_pkg::TERM_ADDR, 8'h12);
      cc_loop_active <= 1'b0;
      rdchk(clcr_pkg::TERM_ADDR, 8'h12);
      chk({term_active, term_current_ua}, 17'h0_09c4);
      @(posedge sys_clk);
      voltage_regulation_loop <= 1'b1;
      repeat (3) @(posedge sys_clk);
      #1 chk(term_active, 1'b1);
   endtask : t_term
   task automatic t_load(input logic g, input logic [7:0] exp);
      @(posedge sys_clk);
      default_load <= 1'b1;
      term_pin_grounded <= g;
      @(posedge sys_clk);
      default_load <= 1'b0;
      rdchk(clcr_pkg::TERM_ADDR, exp);
      rdchk(8'h05, 8'hd3);
   endtask : t_load
   initial begin
      repeat (16) @(posedge sys_clk);
      srst <= 1'b0;
      rdchk(clcr_pkg::TERM_ADDR, 8'h0e);
      rdchk(8'h05, 8'h78);
      rdchk(8'h06, 8'haa);
      rdchk(8'h07, 8'h00);
      chk(system_output_voltage, 8'haa);
      chk(batt_reg_target_mv, 13'h1068);
      chk({term_active, term_current_ua}, 17'h1_07d0);
      HOST.wr(8'h06, 8'h55);
      rdchk(8'h06, 8'h55);
      chk(system_output_voltage, 8'h55);
      t_vbat;
      t_term;
      t_load(1'b1, 8'h86);
      t_load(1'b0, 8'h0a);
      tally_and_finish;
   end
   // Tests need under a hundred cycles; this is ample
   initial begin
      #100000;
      fails++;
      tally_and_finish;
   end
endmodule : charge_limit_config_regs_tb
`default_nettype wire
